/* logic/dpll_output_phase_offset.sv */
// Output phase offset registers and ramp for the DPLL output clock
`timescale 1ns/1ps
module dpll_output_phase_offset
  import phase_offset_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic locked,
  input wire logic realign_event,
  output logic [15:0] applied_offset,
  output logic realign_active,
  output logic realign_pulse,
  output logic [5:0] realign_trim
);
  state_s s_q;
  state_s s_d;
  logic lock_m;
  logic lock_s;
  logic ev_m;
  logic ev_s;
  logic ev_prev;
  logic [15:0] target;
  logic setup;
  logic wr;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_m <= 1'b0;
      lock_s <= 1'b0;
      ev_m <= 1'b0;
      ev_s <= 1'b0;
      ev_prev <= 1'b0;
    end else begin
      lock_m <= locked;
      lock_s <= lock_m;
      ev_m <= realign_event;
      ev_s <= ev_m;
      ev_prev <= ev_s;
    end
  end

  // Upper byte carries sign of offset word
  assign target = {s_q.shift_high, s_q.shift_low};
  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite && s_q.pready;

  always_comb begin
    s_d = s_q;
    s_d.pready = setup;
    s_d.realign_pulse = 1'b0;
    if (setup) begin
      case (paddr)
        shift_low_addr: s_d.prdata = {24'h000000, s_q.shift_low};
        shift_high_addr: s_d.prdata = {24'h000000, s_q.shift_high};
        trim_addr: s_d.prdata = {26'h0000000, s_q.trim};
        control_addr: s_d.prdata = {30'h00000000, s_q.realign_en, s_q.ramp_off};
        applied_addr: s_d.prdata = {16'h0000, s_q.applied};
        default: s_d.prdata = 32'h00000000;
      endcase
    end
    if (wr && pstrb[0]) begin
      case (paddr)
        shift_low_addr: s_d.shift_low = pwdata[7:0];
        shift_high_addr: s_d.shift_high = pwdata[7:0];
        trim_addr: s_d.trim = pwdata[5:0] & trim_mask;
        control_addr: begin
          s_d.ramp_off = pwdata[ctl_ramp_off_bit];
          s_d.realign_en = pwdata[ctl_realign_en_bit];
        end
        default: begin
        end
      endcase
    end
    // Realign active: offset word has no effect
    if (!s_q.realign_en) begin
      if (s_q.ramp_off || !lock_s) begin
        s_d.applied = target;
      end else if (s_q.applied != target) begin
        // One count per cycle toward target
        if ($signed(target) > $signed(s_q.applied)) begin
          s_d.applied = s_q.applied + ramp_step;
        end else begin
          s_d.applied = s_q.applied - ramp_step;
        end
      end
    end
    // Trim handed to realign logic on each rising event edge while realign is enabled
    if (ev_s && !ev_prev && s_q.realign_en) begin
      s_d.realign_pulse = 1'b1;
      s_d.realign_trim = s_q.trim;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '{shift_low: shift_reset, shift_high: shift_reset, trim: trim_reset[5:0],
               ramp_off: 1'b0, realign_en: 1'b0, applied: 16'h0000,
               prdata: 32'h00000000, pready: 1'b0, realign_pulse: 1'b0,
               realign_trim: 6'h00};
    end else begin
      s_q <= s_d;
    end
  end

  // Time per count follows DPLL output period, no correction here
  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = 1'b0;
  assign applied_offset = s_q.applied;
  assign realign_active = s_q.realign_en;
  assign realign_pulse = s_q.realign_pulse;
  assign realign_trim = s_q.realign_trim;

  ramp_step_a: assert property (@(posedge pclk) disable iff (!presetn)
    (lock_s && !s_q.ramp_off && !s_q.realign_en) |=>
    (s_q.applied - $past(s_q.applied) inside {16'h0000, 16'h0001, 16'hFFFF}))
    else $error("ramp moved more than one count");
  ramp_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.ramp_off && !s_q.realign_en) |=> (s_q.applied == $past(target)))
    else $error("direct update missed");
  realign_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.realign_en |=> $stable(s_q.applied))
    else $error("offset changed while realign enabled");
  trim_bits_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.pready && paddr == trim_addr) |-> (prdata[31:6] == 26'h0))
    else $error("trim high bits nonzero");
  trim_pass_a: assert property (@(posedge pclk) disable iff (!presetn)
    realign_pulse |-> (realign_trim == s_q.trim || $past(wr)))
    else $error("trim not passed on event");
  high_byte_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && pstrb[0] && paddr == shift_high_addr) |=> (s_q.shift_high == $past(pwdata[7:0])))
    else $error("high byte write lost");
  // Outside lock, with realign disabled, the offset is taken at once
  unlocked_direct_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!lock_s && !s_q.realign_en) |=> (s_q.applied == $past(target)))
    else $error("unlocked offset not applied directly");
  // Ramp moves toward the target, never away
  ramp_up_a: assert property (@(posedge pclk) disable iff (!presetn)
    (lock_s && !s_q.ramp_off && !s_q.realign_en && ($signed(target) > $signed(s_q.applied)))
    |=> (s_q.applied == $past(s_q.applied) + ramp_step))
    else $error("ramp did not step up");
  ramp_down_a: assert property (@(posedge pclk) disable iff (!presetn)
    (lock_s && !s_q.ramp_off && !s_q.realign_en && ($signed(target) < $signed(s_q.applied)))
    |=> (s_q.applied == $past(s_q.applied) - ramp_step))
    else $error("ramp did not step down");
  // Pulse only follows an event with realign enabled
  pulse_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    realign_pulse |-> $past(s_q.realign_en))
    else $error("realign pulse without enable");
  trim_store_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && pstrb[0] && paddr == trim_addr) |=> (s_q.trim == $past(pwdata[5:0])))
    else $error("trim write lost");
  high_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.pready && paddr == shift_high_addr) |-> (prdata == {24'h000000, s_q.shift_high}))
    else $error("high byte read wrong");
endmodule

/* logic/phase_offset_pkg.sv */
// Constants and types for the output phase offset block
package phase_offset_pkg;
  localparam logic [11:0] shift_low_addr = 12'h000;
  localparam logic [11:0] shift_high_addr = 12'h004;
  localparam logic [11:0] trim_addr = 12'h008;
  localparam logic [11:0] control_addr = 12'h00C;
  localparam logic [11:0] applied_addr = 12'h010;
  localparam logic [7:0] shift_reset = 8'h00;
  localparam logic [7:0] trim_reset = 8'h00;
  localparam logic [5:0] trim_mask = 6'h3F;
  localparam int ctl_ramp_off_bit = 0;
  localparam int ctl_realign_en_bit = 1;
  localparam logic [15:0] ramp_step = 16'h0001;
  localparam logic [15:0] invert_count = 16'h0400;

  typedef struct packed {
    logic [7:0] shift_low;
    logic [7:0] shift_high;
    logic [5:0] trim;
    logic ramp_off;
    logic realign_en;
    logic [15:0] applied;
    logic [31:0] prdata;
    logic pready;
    logic realign_pulse;
    logic [5:0] realign_trim;
  } state_s;
endpackage

/* sim/testbench.sv */
// Self-checking testbench for the output phase offset block
`timescale 1ns/1ps
module testbench;
  import phase_offset_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, locked = 0;
  logic realign_event = 0, pready, pslverr, realign_active, realign_pulse;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [3:0] pstrb = 4'hF;
  logic [15:0] applied_offset, t, u;
  logic [5:0] realign_trim;
  int failures = 0, n_checks = 0, cyc = 0, seed = 5, n, d;
  dpll_output_phase_offset dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .locked(locked),
    .realign_event(realign_event), .applied_offset(applied_offset),
    .realign_active(realign_active), .realign_pulse(realign_pulse),
    .realign_trim(realign_trim));
  always #2.5 pclk = ~pclk;
  task finish_test;
    $display("failures %0d checks %0d", failures, n_checks);
    if (failures == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      failures++;
      $display("mismatch at %0t: got %h want %h", $time, s, e);
    end
  endtask
  // APB transfer, waits for pready
  task bus(input logic w, input logic [11:0] a, input logic [31:0] v);
    @(posedge pclk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= v;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 0; penable <= 0;
  endtask
  task rchk(input logic [11:0] a, input logic [31:0] e);
    bus(0, a, 0);
    chk(rd, e);
  endtask
  always @(posedge pclk) if (++cyc > 40000) begin
    failures++;
    finish_test;
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1;
    rchk(shift_high_addr, 0);
    rchk(trim_addr, 0);
    bus(1, trim_addr, 32'hFF);
    rchk(trim_addr, 32'h3F);
    rchk(12'h020, 0);
    t = $random(seed) & 16'h0FFF;
    bus(1, shift_low_addr, t[7:0]);
    bus(1, shift_high_addr, t[15:8]);
    repeat (4) @(posedge pclk);
    chk(applied_offset, t);
    locked <= 1;
    repeat (4) @(posedge pclk);
    // Ramp while locked: one count per cycle
    u = {t[15:8] ^ (8'h01 + ($random(seed) & 7)), t[7:0]};
    d = u > t ? u - t : t - u;
    bus(1, shift_high_addr, u[15:8]);
    n = 0;
    while (applied_offset !== u && n < 5000) begin
      @(posedge pclk);
      n++;
    end
    chk(applied_offset, u);
    chk(n + 4 >= d, 1);
    chk(n <= d + 2, 1);
    rchk(applied_addr, u);
    pstrb <= 4'h0;
    bus(1, shift_high_addr, 8'h55);
    pstrb <= 4'hF;
    rchk(shift_high_addr, u[15:8]);
    chk(pslverr, 0);
    bus(1, control_addr, 1);
    bus(1, shift_high_addr, 8'h02);
    repeat (4) @(posedge pclk);
    chk(applied_offset, {8'h02, t[7:0]});
    bus(1, control_addr, 2);
    bus(1, shift_high_addr, 8'h07);
    repeat (4) @(posedge pclk);
    chk(realign_active, 1);
    chk(applied_offset, {8'h02, t[7:0]});
    realign_event <= 1;
    n = 0;
    while (realign_pulse !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    chk(realign_pulse, 1);
    chk(realign_trim, 6'h3F);
    rchk(control_addr, 2);
    finish_test;
  end
endmodule
